// File: hdl/result_out_pkg.sv
package result_out_pkg;

   // ==========================================================
   // Word layout
   localparam int COUNT_W = 23;     // Magnitude counter width
   localparam int WORD_W = 24;      // Counter bits then sign bit
   localparam int SIGN_POS = 0;     // Sign travels last, lowest bit
   localparam int MSB_POS = 23;     // First bit sent
   localparam int FIFO_DEPTH = 8;   // Result words held

   // ==========================================================
   // Clocking
   localparam int CLK_MHZ = 200;                 // Main clock rate
   localparam int PRESCALE = 4;                  // System tick divider
   localparam int SYS_MHZ = CLK_MHZ / PRESCALE;  // Conversion tick rate

   // ==========================================================
   // Timing figures in their own units, then cycle counts
   localparam real TIMEOUT_MS = 5.5;     // Readout watchdog, longest
   localparam real INT_MS = 100.0;       // Default integrate time
   localparam real IZ_MS = 2.0;          // Integrator zero time
   localparam real AZ_MS = 100.0;        // Auto-zero, same as integrate
   // Longest time rounds down, in main clock cycles
   localparam int TIMEOUT_CYCLES = int'($floor(TIMEOUT_MS * 1000.0 * CLK_MHZ));
   // Phase lengths in system ticks
   localparam int INT_TICKS = int'($floor(INT_MS * 1000.0 * SYS_MHZ));
   localparam int IZ_TICKS = int'($floor(IZ_MS * 1000.0 * SYS_MHZ));
   localparam int AZ_TICKS = int'($floor(AZ_MS * 1000.0 * SYS_MHZ));

   // ==========================================================
   // Reset values
   localparam logic DV_IDLE = 1'b1;     // Data valid is active low
   localparam logic PIN_IDLE = 1'b1;    // Idle level of strobe pin

   // ==========================================================
   // Conversion phases, coded as {phase_a, phase_b}
   typedef enum logic [1:0] {
      PH_AZ = 2'b00,
      PH_INT = 2'b01,
      PH_DEINT = 2'b10,
      PH_IZ = 2'b11
   } phase_type;

   // Readout states
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_SHOW = 2'b01,
      RD_GAP = 2'b10
   } rd_state_type;

endpackage

// File: hdl/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   // ==========================================================
   // Pointers and fill count
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      cnt_nxt = cnt_r;
      if (push) begin
         wr_nxt = (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
         rd_nxt = (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

endmodule

`default_nettype wire

// File: hdl/result_out_ctrl.sv
// Function
// - Conversion count lands in a 23-bit counter, offered for shifting after each cycle.
// - Sign bit is 1 for positive input, 0 for negative, sent 24th.
// - Word is counter MSB to LSB, then sign; host gives 24 strobes.
// - Data valid stays high while a conversion runs.
// - At readout start data valid falls with counter MSB on dout.
// - Each of the first 23 strobes raises data valid, shifts next bit, lowers it again.
// - After 24 bits data valid rises, integrate starts, stays high.
// - No strobe within 5.5 ms of first fall: time out, restart conversion.
// - Two phase outputs select four analog phases; comparator is an input.
// - System tick runs at one quarter of the input clock.
// - Data valid low only in auto-zero; high in every other phase.
// - Chip select high floats data valid and dout.
`timescale 1ns/1ps
`default_nettype none

module result_out_ctrl
   import result_out_pkg::*;
#(
   parameter int INT_LEN = INT_TICKS,
   parameter int AZ_LEN = AZ_TICKS,
   parameter int IZ_LEN = IZ_TICKS,
   parameter int TIMEOUT_LEN = TIMEOUT_CYCLES
) (
   // Clocks and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   // Host side pins
   input wire logic cs_n,
   input wire logic strobe_n,
   output logic data_valid_n,
   output logic data_valid_oe,
   output logic dout,
   output logic dout_oe,
   // Analog front end
   output logic phase_a,
   output logic phase_b,
   input wire logic comparator
);

   localparam int TO_W = $clog2(TIMEOUT_LEN + 1);

   // ==========================================================
   // Link domain: strobe pin capture
   logic rst_l1_r, rst_l2_r;
   logic stb_s1_r, stb_s2_r, stb_prev_r, stb_low_r, stb_tgl_r;
   logic stb_low_nxt, stb_tgl_nxt;

   // Reset carried into the link domain
   always_ff @(posedge link_clk) begin
      rst_l1_r <= rst;
      rst_l2_r <= rst_l1_r;
   end

   // Pulse counted only once a fall has been seen, then a rise
   always_comb begin
      stb_low_nxt = stb_low_r;
      stb_tgl_nxt = stb_tgl_r;
      if (stb_prev_r && !stb_s2_r) begin
         stb_low_nxt = 1'b1;
      end
      if (!stb_prev_r && stb_s2_r && stb_low_r) begin
         stb_low_nxt = 1'b0;
         stb_tgl_nxt = ~stb_tgl_r;
      end
   end

   always_ff @(posedge link_clk) begin
      if (rst_l2_r) begin
         stb_s1_r <= PIN_IDLE;
         stb_s2_r <= PIN_IDLE;
         stb_prev_r <= PIN_IDLE;
         stb_low_r <= 1'b0;
         stb_tgl_r <= 1'b0;
      end else begin
         stb_s1_r <= strobe_n;
         stb_s2_r <= stb_s1_r;
         stb_prev_r <= stb_s2_r;
         stb_low_r <= stb_low_nxt;
         stb_tgl_r <= stb_tgl_nxt;
      end
   end

   // ==========================================================
   // Main domain: synchronisers and tick
   logic tgl_s1_r, tgl_s2_r, tgl_prev_r;
   logic cs_s1_r, cs_s2_r, cmp_s1_r, cmp_s2_r;
   logic [1:0] pre_r, pre_nxt;
   logic tick, strobe_ev;

   // A toggle survives the crossing when the link clock is the slower of the two clocks
   assign strobe_ev = tgl_s2_r ^ tgl_prev_r;
   assign tick = (pre_r == 2'(PRESCALE - 1));

   // Divide by four for the conversion timebase
   always_comb begin
      pre_nxt = pre_r + 2'h1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_prev_r <= 1'b0;
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cmp_s1_r <= 1'b0;
         cmp_s2_r <= 1'b0;
         pre_r <= 2'h0;
      end else begin
         tgl_s1_r <= stb_tgl_r;
         tgl_s2_r <= tgl_s1_r;
         tgl_prev_r <= tgl_s2_r;
         cs_s1_r <= cs_n;
         cs_s2_r <= cs_s1_r;
         cmp_s1_r <= comparator;
         cmp_s2_r <= cmp_s1_r;
         pre_r <= pre_nxt;
      end
   end

   // ==========================================================
   // Conversion sequencer
   phase_type phase_r, phase_nxt;
   logic [31:0] tcnt_r, tcnt_nxt;
   logic [COUNT_W-1:0] count_r, count_nxt;
   logic sign_r, sign_nxt;
   logic fifo_in_valid, fifo_in_ready;
   logic [WORD_W-1:0] fifo_in_data;
   logic rd_busy, rd_done;
   logic fifo_out_valid, fifo_out_ready;
   logic [WORD_W-1:0] fifo_out_data;

   // Result complete at zero crossing or when the counter saturates
   assign fifo_in_valid = (phase_r == PH_DEINT) && (!cmp_s2_r || (&count_r));
   assign fifo_in_data = {count_r, sign_r};
   assign phase_a = phase_r[1];
   assign phase_b = phase_r[0];

   // A full buffer holds auto-zero, so no finished word is ever dropped
   always_comb begin
      phase_nxt = phase_r;
      tcnt_nxt = tcnt_r;
      count_nxt = count_r;
      sign_nxt = sign_r;
      case (phase_r)
         PH_AZ: begin
            if (tick) begin
               tcnt_nxt = tcnt_r + 32'h1;
            end
            if (rd_done) begin
               phase_nxt = PH_INT;
               tcnt_nxt = '0;
            end else if (!rd_busy && fifo_in_ready && tick && tcnt_r >= 32'(AZ_LEN - 1)) begin
               phase_nxt = PH_INT;
               tcnt_nxt = '0;
            end
         end
         PH_INT: begin
            if (tick) begin
               tcnt_nxt = tcnt_r + 32'h1;
               if (tcnt_r == 32'(INT_LEN - 1)) begin
                  phase_nxt = PH_DEINT;
                  sign_nxt = cmp_s2_r;
                  count_nxt = '0;
                  tcnt_nxt = '0;
               end
            end
         end
         PH_DEINT: begin
            if (fifo_in_valid) begin
               if (fifo_in_ready) begin
                  phase_nxt = PH_IZ;
               end
            end else if (tick) begin
               count_nxt = count_r + 1'b1;
            end
         end
         PH_IZ: begin
            if (tick) begin
               tcnt_nxt = tcnt_r + 32'h1;
               if (tcnt_r == 32'(IZ_LEN - 1)) begin
                  phase_nxt = PH_AZ;
                  tcnt_nxt = '0;
               end
            end
         end
         default: begin
            phase_nxt = PH_AZ;
            tcnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         phase_r <= PH_AZ;
         tcnt_r <= '0;
         count_r <= '0;
         sign_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         tcnt_r <= tcnt_nxt;
         count_r <= count_nxt;
         sign_r <= sign_nxt;
      end
   end

   // ==========================================================
   // Result buffer
   word_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // ==========================================================
   // Serial readout
   rd_state_type rd_state_r, rd_state_nxt;
   logic [WORD_W-1:0] shreg_r, shreg_nxt;
   logic [4:0] bits_r, bits_nxt;
   logic [TO_W-1:0] to_r, to_nxt;
   logic dv_r, dv_nxt, dout_r, dout_nxt, dv_oe_r, dout_oe_r;
   logic rd_start, last_bit, to_hit;

   // Only a selected device hands out a word, and only in auto-zero
   assign rd_start = (rd_state_r == RD_IDLE) && (phase_r == PH_AZ) && fifo_out_valid
      && !cs_s2_r;
   assign fifo_out_ready = rd_start;
   assign rd_busy = (rd_state_r != RD_IDLE) || rd_start;
   assign last_bit = (bits_r == 5'(WORD_W - 1));
   assign to_hit = (to_r == TO_W'(TIMEOUT_LEN - 1));
   assign data_valid_n = dv_r;
   assign dout = dout_r;
   assign data_valid_oe = dv_oe_r;
   assign dout_oe = dout_oe_r;

   always_comb begin
      rd_state_nxt = rd_state_r;
      shreg_nxt = shreg_r;
      bits_nxt = bits_r;
      to_nxt = to_r;
      dv_nxt = dv_r;
      dout_nxt = dout_r;
      rd_done = 1'b0;
      case (rd_state_r)
         RD_IDLE: begin
            dv_nxt = DV_IDLE;
            if (rd_start) begin
               shreg_nxt = fifo_out_data;
               dout_nxt = fifo_out_data[MSB_POS];
               dv_nxt = 1'b0;
               bits_nxt = '0;
               to_nxt = '0;
               rd_state_nxt = RD_SHOW;
            end
         end
         RD_SHOW: begin
            // Watchdog runs across the whole word, never rearmed
            to_nxt = to_r + 1'b1;
            if (strobe_ev) begin
               dv_nxt = 1'b1;
               shreg_nxt = {shreg_r[WORD_W-2:0], 1'b0};
               bits_nxt = bits_r + 5'h1;
               if (last_bit) begin
                  rd_state_nxt = RD_IDLE;
                  rd_done = 1'b1;
               end else begin
                  rd_state_nxt = RD_GAP;
               end
            end else if (to_hit) begin
               dv_nxt = 1'b1;
               rd_state_nxt = RD_IDLE;
               rd_done = 1'b1;
            end
         end
         RD_GAP: begin
            to_nxt = to_r + 1'b1;
            dout_nxt = shreg_r[MSB_POS];
            dv_nxt = 1'b0;
            rd_state_nxt = RD_SHOW;
         end
         default: begin
            rd_state_nxt = RD_IDLE;
            dv_nxt = DV_IDLE;
         end
      endcase
   end

   // Enables are registered so the pins float cleanly with chip select
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_state_r <= RD_IDLE;
         shreg_r <= '0;
         bits_r <= '0;
         to_r <= '0;
         dv_r <= DV_IDLE;
         dout_r <= 1'b0;
         dv_oe_r <= 1'b0;
         dout_oe_r <= 1'b0;
      end else begin
         rd_state_r <= rd_state_nxt;
         shreg_r <= shreg_nxt;
         bits_r <= bits_nxt;
         to_r <= to_nxt;
         dv_r <= dv_nxt;
         dout_r <= dout_nxt;
         dv_oe_r <= !cs_s2_r;
         dout_oe_r <= !cs_s2_r;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_dv_only_az: assert property (!data_valid_n |-> phase_r == PH_AZ)
      else $error("data valid low outside auto-zero");
   a_dv_high_conv: assert property (phase_r != PH_AZ |-> data_valid_n)
      else $error("data valid low during conversion");
   a_first_bit_msb: assert property (rd_start |=> !data_valid_n && dout == $past(fifo_out_data[MSB_POS]))
      else $error("first bit not counter msb");
   a_strobe_cycle: assert property (rd_state_r == RD_SHOW && strobe_ev && !last_bit
      |=> data_valid_n ##1 (!data_valid_n && dout == $past(shreg_r[MSB_POS])))
      else $error("strobe cycle wrong");
   a_last_bit_int: assert property (rd_state_r == RD_SHOW && strobe_ev && last_bit
      |=> data_valid_n && phase_r == PH_INT)
      else $error("word end did not start integrate");
   a_timeout_exit: assert property (rd_state_r == RD_SHOW && !strobe_ev && to_hit
      |=> data_valid_n && rd_state_r == RD_IDLE ##1 phase_r == PH_INT)
      else $error("timeout not taken");
   a_tick_quarter: assert property (tick |=> !tick [*3] ##1 tick)
      else $error("tick not one in four");
   a_float_cs: assert property (cs_s2_r |=> !data_valid_oe && !dout_oe)
      else $error("pins driven while deselected");
   a_bits_cleared: assert property (rd_start |=> bits_r == 5'h0 && to_r == '0)
      else $error("readout counters not cleared");
   a_sign_capture: assert property (phase_r == PH_INT ##1 phase_r == PH_DEINT
      |-> sign_r == $past(cmp_s2_r))
      else $error("sign not captured at integrate end");
   a_result_push: assert property (phase_r == PH_DEINT && !cmp_s2_r |-> fifo_in_valid
      && fifo_in_data[WORD_W-1:1] == count_r)
      else $error("result not offered");
   a_pulse_rise: assert property (@(posedge link_clk) disable iff (rst_l2_r)
      $changed(stb_tgl_r) |-> $past(stb_low_r) && $past(stb_s2_r))
      else $error("strobe counted without fall then rise");

   c_word_done: cover property (rd_state_r == RD_SHOW && strobe_ev && last_bit);
   c_timeout: cover property (rd_state_r == RD_SHOW && to_hit && !strobe_ev);
   c_fifo_full: cover property (!fifo_in_ready);
   c_deselected: cover property (cs_s2_r && phase_r == PH_AZ);

endmodule

`default_nettype wire

// File: verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host processor reading result words over the strobe handshake
module host_model (
   // Pacing clock
   input wire logic clk,
   // Device pins
   input wire logic data_valid_n,
   input wire logic data_valid_oe,
   input wire logic dout,
   input wire logic dout_oe,
   output logic strobe_n
);
   logic dout_last;
   logic dv_line;
   logic dout_line;

   // Pull-up on data valid; a floating dout shows its last level inverted
   assign dv_line = data_valid_oe ? data_valid_n : 1'b1;
   assign dout_line = dout_oe ? dout : ~dout_last;

   // Remember the last driven dout level
   always @(posedge clk) begin
      if (dout_oe) begin
         dout_last <= dout;
      end
   end

   initial begin
      strobe_n = 1'b1;
      dout_last = 1'b0;
   end

   // Poll data valid at falling edges, bounded
   task automatic wait_dv(input logic lvl, input int lim, output logic ok);
      ok = 1'b0;
      for (int i = 0; i < lim && !ok; i++) begin
         @(negedge clk);
         ok = (dv_line === lvl);
      end
   endtask

   // One whole word: sample, strobe, wait for the next bit
   task automatic read_word(output logic [23:0] w, output logic ok);
      logic got;
      ok = 1'b1;
      w = 24'h000000;
      wait_dv(1'b0, 3000, got);
      ok = ok & got;
      // Exactly 24 pulses, first one well inside the watchdog
      for (int b = 0; b < 24; b++) begin
         w[23-b] = dout_line;
         // Low then high, each level over three link periods
         strobe_n = 1'b0;
         repeat (100) @(negedge clk);
         strobe_n = 1'b1;
         wait_dv(1'b1, 400, got);
         ok = ok & got;
         if (b < 23) begin
            wait_dv(1'b0, 20, got);
            ok = ok & got;
            // Keep the high level long enough for the link side
            repeat (100) @(negedge clk);
         end
      end
   endtask
endmodule

`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import result_out_pkg::*;

   localparam int TO_LEN = 20000;
   localparam int DEINT_TICKS = 50;
   localparam int RST_CYC = 128;

   logic clk = 1'b0;
   logic link_clk;
   logic rst;
   logic cs_n;
   logic strobe_n;
   logic data_valid_n;
   logic data_valid_oe;
   logic dout;
   logic dout_oe;
   logic phase_a;
   logic phase_b;
   logic comparator;
   logic want_pos;
   int deint_cnt;
   int fails = 0;
   int compares = 0;

   // ==========================================================
   // Clocks: link clock unrelated in phase
   always #2.5 clk = ~clk;
   initial begin
      link_clk = 1'b0;
      #37;
      forever #80 link_clk = ~link_clk;
   end

   result_out_ctrl #(.INT_LEN(20), .AZ_LEN(10), .IZ_LEN(5), .TIMEOUT_LEN(TO_LEN)) dut (
      .clk(clk), .rst(rst), .link_clk(link_clk), .cs_n(cs_n), .strobe_n(strobe_n),
      .data_valid_n(data_valid_n), .data_valid_oe(data_valid_oe), .dout(dout),
      .dout_oe(dout_oe), .phase_a(phase_a), .phase_b(phase_b), .comparator(comparator));

   host_model host (
      .clk(clk), .data_valid_n(data_valid_n), .data_valid_oe(data_valid_oe),
      .dout(dout), .dout_oe(dout_oe), .strobe_n(strobe_n));

   // ==========================================================
   // Analog front end: sign set in integrate, zero crossing after a fixed time
   always @(negedge clk) begin
      if ({phase_a, phase_b} == 2'b01) begin
         comparator <= want_pos;
         deint_cnt <= 0;
      end else if ({phase_a, phase_b} == 2'b10) begin
         deint_cnt <= deint_cnt + 1;
         if (deint_cnt >= 4 * DEINT_TICKS) begin
            comparator <= 1'b0;
         end
      end
   end

   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Data valid must stay high outside auto-zero
   always @(negedge clk) begin
      if (!rst && data_valid_oe === 1'b1 && {phase_a, phase_b} !== 2'b00) begin
         check("dv_outside_az", {23'h0, data_valid_n}, 24'h1);
      end
   end

   task automatic finish_test();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ==========================================================
   // Buffer filled while deselected: auto-zero holds, oldest word kept intact
   task automatic scen_fifo();
      int held;
      int n;
      logic [23:0] w;
      logic ok;
      logic in_win;
      held = 0;
      n = 0;
      while (held < 200 && n < 5000) begin
         @(negedge clk);
         n++;
         held = ({phase_a, phase_b} == 2'b00) ? held + 1 : 0;
      end
      check("buffer_full_hold", {23'h0, held >= 200}, 24'h1);
      check("dv_oe_waiting", {23'h0, data_valid_oe}, 24'h0);
      cs_n = 1'b0;
      host.read_word(w, ok);
      check("buffered_read", {23'h0, ok}, 24'h1);
      check("buffered_sign", {23'h0, w[0]}, 24'h1);
      in_win = (w[23:1] >= 23'(DEINT_TICKS - 4)) && (w[23:1] <= 23'(DEINT_TICKS + 4));
      check("buffered_count", {23'h0, in_win}, 24'h1);
      // Mid-run reset flushes the words still buffered
      cs_n = 1'b1;
      rst = 1'b1;
      repeat (RST_CYC) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check("rst_phase", {22'h0, phase_a, phase_b}, 24'h0);
      check("rst_dv", {23'h0, data_valid_n}, 24'h1);
      check("rst_dv_oe", {23'h0, data_valid_oe}, 24'h0);
      $display("test fifo done");
   endtask

   // Pins float while deselected, driven once selected
   task automatic scen_select();
      repeat (10) @(negedge clk);
      check("dv_oe_desel", {23'h0, data_valid_oe}, 24'h0);
      check("dout_oe_desel", {23'h0, dout_oe}, 24'h0);
      cs_n = 1'b0;
      repeat (10) @(negedge clk);
      check("dv_oe_sel", {23'h0, data_valid_oe}, 24'h1);
      check("dout_oe_sel", {23'h0, dout_oe}, 24'h1);
      check("dv_idle", {23'h0, data_valid_n}, 24'h1);
      $display("test select done");
   endtask

   // Full readout, then integrate must start
   task automatic scen_read(input logic exp_sign, input logic next_sign, input logic chk_cnt);
      logic [23:0] w;
      logic ok;
      logic in_win;
      host.read_word(w, ok);
      // Sign for the conversion that this readout's end starts
      want_pos = next_sign;
      check("handshake", {23'h0, ok}, 24'h1);
      check("sign_bit", {23'h0, w[0]}, {23'h0, exp_sign});
      in_win = (w[23:1] >= 23'(DEINT_TICKS - 4)) && (w[23:1] <= 23'(DEINT_TICKS + 4));
      if (chk_cnt) begin
         check("count_window", {23'h0, in_win}, 24'h1);
      end
      check("phase_after", {22'h0, phase_a, phase_b}, 24'h1);
      $display("test read sign %0d done", exp_sign);
   endtask

   // Word left unread: watchdog raises data valid
   task automatic scen_timeout();
      int n;
      logic ok;
      want_pos = 1'b1;
      host.wait_dv(1'b0, 3000, ok);
      check("word_ready", {23'h0, ok}, 24'h1);
      n = 0;
      while (host.dv_line === 1'b0 && n < TO_LEN + 100) begin
         @(negedge clk);
         n++;
      end
      check("timeout_len", {23'h0, (n >= TO_LEN - 5) && (n <= TO_LEN + 5)}, 24'h1);
      repeat (50) @(negedge clk);
      check("dv_after_timeout", {23'h0, host.dv_line}, 24'h1);
      $display("test timeout done");
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      finish_test();
   end

   // Reset spans four link periods so the link side sees it
   initial begin
      rst = 1'b1;
      cs_n = 1'b1;
      comparator = 1'b0;
      want_pos = 1'b1;
      repeat (RST_CYC) @(negedge clk);
      rst = 1'b0;
      scen_fifo();
      scen_select();
      scen_read(1'b1, 1'b0, 1'b1);
      scen_read(1'b0, 1'b1, 1'b0);
      scen_timeout();
      finish_test();
   end
endmodule

`default_nettype wire
